// ===== hw/abo_top.sv
// axis zero trim and 32-entry sample buffer with APB registers
// assumes sensor inputs are synchronous to pclk, events are pulses
// Notes on behaviour
// - three 8-bit signed axis trim registers
// - trim adds twice one output count
// - order bit 0 reads oldest first
// - order bit 1 reads newest first
// - setup writes only when inactive, pin free
// - mode 00 stores nothing
// - mode 01 overwrites oldest when full
// - mode 10 stops storing when full
// - mode 11 keeps watermark pre-trigger samples
// - after trigger, 32 minus watermark, then overflow
// - pre-trigger count from watermark bits 5:0
// - flush or full readout clears overflow, re-arms
// - three trigger sources, enables bits 3,2,0
// - gate bit 0 flushes on power change
// - disabling empties buffer and clears overflow, trigger and gate flags
`timescale 1ns/1ps
`default_nettype none
module abo_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [abo_pkg::ABO_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sample_valid,
	input wire logic [abo_pkg::ABO_SW-1:0] raw_x,
	input wire logic [abo_pkg::ABO_SW-1:0] raw_y,
	input wire logic [abo_pkg::ABO_SW-1:0] raw_z,
	input wire logic sensor_active,
	input wire logic pin_two_function_select,
	input wire logic power_mode_change,
	input wire logic buffer_flush,
	input wire logic change_inband_evt,
	input wire logic change_outband_evt,
	input wire logic tilt_change_evt,
	input wire logic [5:0] watermark_level,
	output logic out_valid,
	output logic [abo_pkg::ABO_SW-1:0] out_x,
	output logic [abo_pkg::ABO_SW-1:0] out_y,
	output logic [abo_pkg::ABO_SW-1:0] out_z,
	output logic buffer_overflow_flag,
	output logic [abo_pkg::ABO_CW-1:0] buffer_count,
	output logic irq
);
	import abo_pkg::*;

	logic [7:0] trim_x;
	logic [7:0] trim_y;
	logic [7:0] trim_z;
	logic [7:0] setup;
	logic [ABO_NEV-1:0] irq_mask;
	logic [ABO_NEV-1:0] irq_stat;
	logic [ABO_SW-1:0] cor_x;
	logic [ABO_SW-1:0] cor_y;
	logic [ABO_SW-1:0] cor_z;
	logic [3*ABO_SW-1:0] store [ABO_DEPTH];
	logic [ABO_PW-1:0] wr_ptr;
	logic [ABO_CW-1:0] count;
	logic [ABO_CW-1:0] post_cnt;
	logic triggered;
	logic gated;
	logic active_q;
	logic [1:0] mode;
	logic lifo;
	logic [ABO_CW-1:0] cap;
	logic [ABO_CW-1:0] post_limit;
	logic [ABO_PW-1:0] rd_idx;
	logic [3*ABO_SW-1:0] head;
	logic flush;
	logic trig_hit;
	logic push;
	logic grow;
	logic drop;
	logic set_ovf;
	logic acc;
	logic stall;
	logic take;
	logic wr_en;
	logic pop;
	logic mapped;
	logic [31:0] rdata_c;
	logic [ABO_NEV-1:0] ev_set;
	logic [ABO_NEV-1:0] ev_clr;

	assign mode = setup[ABO_F_MODE_HI:ABO_F_MODE_LO];
	assign lifo = setup[ABO_F_TYPE];

	// ****************************************************
	// axis trim
	// ****************************************************
	abo_trim_add u_trim_x (
		.raw(raw_x),
		.trim(trim_x),
		.corrected(cor_x)
	);
	abo_trim_add u_trim_y (
		.raw(raw_y),
		.trim(trim_y),
		.corrected(cor_y)
	);
	abo_trim_add u_trim_z (
		.raw(raw_z),
		.trim(trim_z),
		.corrected(cor_z)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_valid <= 1'b0;
			out_x <= '0;
			out_y <= '0;
			out_z <= '0;
		end else begin
			out_valid <= sample_valid;
			if (sample_valid) begin
				out_x <= cor_x;
				out_y <= cor_y;
				out_z <= cor_z;
			end
		end
	end

	// ****************************************************
	// apb slave
	// ****************************************************
	// one wait state; a popping read waits while a sample lands
	assign acc = psel & penable;
	assign stall = ~pwrite & (paddr == ABO_ADDR_DATA_HI) & sample_valid;
	assign take = acc & ~pready & ~stall;
	assign wr_en = acc & pready & pwrite;
	assign pop = take & ~pwrite & (paddr == ABO_ADDR_DATA_HI) & (count != '0);

	always_comb begin
		mapped = 1'b1;
		rdata_c = 32'h0;
		case (paddr)
			ABO_ADDR_TRIM_X: rdata_c = {24'h0, trim_x};
			ABO_ADDR_TRIM_Y: rdata_c = {24'h0, trim_y};
			ABO_ADDR_TRIM_Z: rdata_c = {24'h0, trim_z};
			ABO_ADDR_SETUP: rdata_c = {24'h0, setup};
			ABO_ADDR_DATA_LO: rdata_c = {4'h0, head[23:12], 4'h0, head[11:0]};
			ABO_ADDR_DATA_HI: rdata_c = {20'h0, head[35:24]};
			ABO_ADDR_STATUS: rdata_c = {23'h0, gated, triggered, buffer_overflow_flag, count};
			ABO_ADDR_IRQ_STAT: rdata_c = {29'h0, irq_stat};
			ABO_ADDR_IRQ_MASK: rdata_c = {29'h0, irq_mask};
			default: mapped = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= take;
			pslverr <= take & ~mapped;
			if (take) begin
				prdata <= (pwrite | ~mapped) ? 32'h0 : rdata_c;
			end
		end
	end

	// ****************************************************
	// configuration registers
	// ****************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trim_x <= ABO_TRIM_RST;
			trim_y <= ABO_TRIM_RST;
			trim_z <= ABO_TRIM_RST;
			setup <= ABO_SETUP_RST;
			irq_mask <= ABO_MASK_RST;
		end else if (wr_en) begin
			case (paddr)
				ABO_ADDR_TRIM_X: trim_x <= pwdata[7:0];
				ABO_ADDR_TRIM_Y: trim_y <= pwdata[7:0];
				ABO_ADDR_TRIM_Z: trim_z <= pwdata[7:0];
				ABO_ADDR_SETUP: begin
					if (!sensor_active && !pin_two_function_select) begin
						setup <= pwdata[7:0];
					end
				end
				ABO_ADDR_IRQ_MASK: irq_mask <= pwdata[ABO_NEV-1:0];
				default: ;
			endcase
		end
	end

	// ****************************************************
	// buffer control
	// ****************************************************
	assign cap = (watermark_level > ABO_DEPTH_C) ? ABO_DEPTH_C : watermark_level;
	assign post_limit = ABO_DEPTH_C - cap;
	assign rd_idx = lifo ? wr_ptr - 5'h1 : wr_ptr - count[ABO_PW-1:0];
	assign head = store[rd_idx];
	assign trig_hit = (change_inband_evt & setup[ABO_F_TRIG_IN])
		| (change_outband_evt & setup[ABO_F_TRIG_OUT])
		| (tilt_change_evt & setup[ABO_F_TRIG_TILT]);
	assign flush = buffer_flush | (mode == ABO_MODE_OFF)
		| (power_mode_change & ~setup[ABO_F_GATE])
		| (sensor_active & ~active_q);

	always_comb begin
		push = 1'b0;
		grow = 1'b0;
		drop = 1'b0;
		set_ovf = 1'b0;
		if (sample_valid && gated) begin
			drop = 1'b1;
		end else if (sample_valid) begin
			unique case (mode)
				ABO_MODE_OFF: ;
				ABO_MODE_STREAM: begin
					push = 1'b1;
					grow = count < ABO_DEPTH_C;
					set_ovf = ~grow;
				end
				ABO_MODE_STOP: begin
					push = count < ABO_DEPTH_C;
					grow = push;
					drop = ~push;
					set_ovf = ~push;
				end
				ABO_MODE_TRIG: begin
					if (!triggered) begin
						push = 1'b1;
						grow = count < cap;
					end else if (post_cnt < post_limit && count < ABO_DEPTH_C) begin
						push = 1'b1;
						grow = 1'b1;
					end else begin
						drop = 1'b1;
					end
				end
			endcase
		end
		if (mode == ABO_MODE_TRIG && triggered && post_cnt >= post_limit) begin
			set_ovf = 1'b1;
		end
	end

	always_ff @(posedge pclk) begin
		if (push && !flush) begin
			store[wr_ptr] <= {cor_z, cor_y, cor_x};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_q <= 1'b0;
		end else begin
			active_q <= sensor_active;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr <= '0;
			count <= '0;
			post_cnt <= '0;
			triggered <= 1'b0;
			gated <= 1'b0;
			buffer_overflow_flag <= 1'b0;
		end else if (flush) begin
			wr_ptr <= '0;
			count <= '0;
			post_cnt <= '0;
			triggered <= 1'b0;
			gated <= 1'b0;
			buffer_overflow_flag <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 5'h1;
				count <= count + {5'h0, grow};
				if (triggered) begin
					post_cnt <= post_cnt + 6'h1;
				end
			end else if (pop) begin
				count <= count - 6'h1;
				if (lifo) begin
					wr_ptr <= wr_ptr - 5'h1;
				end
			end
			if (pop && count == 6'h1) begin
				buffer_overflow_flag <= 1'b0;
				triggered <= 1'b0;
				post_cnt <= '0;
				gated <= 1'b0;
			end else begin
				if (set_ovf) begin
					buffer_overflow_flag <= 1'b1;
				end
				if (mode == ABO_MODE_TRIG && !triggered && trig_hit) begin
					triggered <= 1'b1;
				end
				if (power_mode_change && setup[ABO_F_GATE] && count != '0) begin
					gated <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			buffer_count <= '0;
		end else begin
			buffer_count <= flush ? 6'h0 : count;
		end
	end

	// ****************************************************
	// interrupts
	// ****************************************************
	assign ev_set[ABO_EV_OVF] = ~flush & set_ovf & ~buffer_overflow_flag;
	assign ev_set[ABO_EV_TRIG] = ~flush & (mode == ABO_MODE_TRIG) & ~triggered & trig_hit;
	assign ev_set[ABO_EV_DROP] = ~flush & drop;

	generate
		for (genvar i = 0; i < ABO_NEV; i++) begin : g_ev
			assign ev_clr[i] = wr_en & (paddr == ABO_ADDR_IRQ_STAT) & pwdata[i];
			abo_event_flag u_flag (
				.pclk(pclk),
				.presetn(presetn),
				.set(ev_set[i]),
				.clr(ev_clr[i]),
				.flag(irq_stat[i])
			);
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat & irq_mask);
		end
	end

	// ****************************************************
	// assertions
	// ****************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	mode_off_empty_a: assert property ((mode == ABO_MODE_OFF) |=> (count == 6'h0))
		else $error("buffer holds samples while disabled");
	stream_full_a: assert property ((mode == ABO_MODE_STREAM) && count == ABO_DEPTH_C
		&& sample_valid && !gated && !flush |=> count == ABO_DEPTH_C
		&& wr_ptr == $past(wr_ptr) + 5'h1)
		else $error("stream mode did not overwrite oldest");
	stop_full_a: assert property ((mode == ABO_MODE_STOP) && count == ABO_DEPTH_C
		&& sample_valid |-> !push)
		else $error("stop mode stored into a full buffer");
	pre_cap_a: assert property ((mode == ABO_MODE_TRIG) && !triggered && count >= cap
		&& sample_valid && !gated && !flush |=> count == $past(count))
		else $error("pre-trigger count exceeded watermark");
	post_ovf_a: assert property ((mode == ABO_MODE_TRIG) && triggered
		&& post_cnt >= post_limit && !flush && !pop |=> buffer_overflow_flag)
		else $error("overflow not set after post-trigger samples");
	cfg_guard_a: assert property (wr_en && paddr == ABO_ADDR_SETUP
		&& (sensor_active || pin_two_function_select) |=> $stable(setup))
		else $error("setup changed while active");
	fifo_pop_a: assert property (pop && !lifo && !flush |=> count == $past(count) - 6'h1
		&& $stable(wr_ptr))
		else $error("oldest-first pop moved the write pointer");
	lifo_pop_a: assert property (pop && lifo && !flush |=> wr_ptr == $past(wr_ptr) - 5'h1)
		else $error("newest-first pop did not step back");
	rearm_a: assert property (pop && count == 6'h1 |=> !triggered && !buffer_overflow_flag)
		else $error("trigger not re-armed after readout");
	power_flush_a: assert property (power_mode_change && !setup[ABO_F_GATE] |=> count == 6'h0
		##1 buffer_count == 6'h0)
		else $error("power change did not flush");
	trig_src_a: assert property ((mode == ABO_MODE_TRIG) && !triggered && !flush
		&& !(pop && count == 6'h1) && tilt_change_evt && setup[ABO_F_TRIG_TILT]
		|=> triggered)
		else $error("enabled trigger source ignored");

	full_stream_c: cover property ((mode == ABO_MODE_STREAM) && count == ABO_DEPTH_C && push);
	trig_done_c: cover property (triggered ##[1:100] buffer_overflow_flag);
	lifo_read_c: cover property (pop && lifo);
	irq_c: cover property (irq);
endmodule
`default_nettype wire

// ===== hw/abo_pkg.sv
// constants shared by the axis trim and sample buffer block
// assumes one 40 MHz clock and APB with 32-bit data
package abo_pkg;

	// ****************************************************
	// widths and depths
	// ****************************************************
	localparam int ABO_SW = 12;
	localparam int ABO_TW = 8;
	localparam int ABO_DEPTH = 32;
	localparam int ABO_PW = 5;
	localparam int ABO_CW = 6;
	localparam int ABO_AW = 8;
	localparam int ABO_NEV = 3;
	localparam logic [ABO_CW-1:0] ABO_DEPTH_C = 6'h20;
	localparam int ABO_CLK_NS = 25;

	// ****************************************************
	// register indices and byte addresses
	// ****************************************************
	localparam logic [7:0] ABO_IDX_TRIM_X = 8'h22;
	localparam logic [7:0] ABO_IDX_TRIM_Y = 8'h23;
	localparam logic [7:0] ABO_IDX_TRIM_Z = 8'h24;
	localparam logic [7:0] ABO_IDX_SETUP = 8'h26;
	localparam logic [7:0] ABO_IDX_DATA_LO = 8'h28;
	localparam logic [7:0] ABO_IDX_DATA_HI = 8'h29;
	localparam logic [7:0] ABO_IDX_STATUS = 8'h2a;
	localparam logic [7:0] ABO_IDX_IRQ_STAT = 8'h2b;
	localparam logic [7:0] ABO_IDX_IRQ_MASK = 8'h2c;
	localparam logic [7:0] ABO_ADDR_TRIM_X = 8'(ABO_IDX_TRIM_X * 4);
	localparam logic [7:0] ABO_ADDR_TRIM_Y = 8'(ABO_IDX_TRIM_Y * 4);
	localparam logic [7:0] ABO_ADDR_TRIM_Z = 8'(ABO_IDX_TRIM_Z * 4);
	localparam logic [7:0] ABO_ADDR_SETUP = 8'(ABO_IDX_SETUP * 4);
	localparam logic [7:0] ABO_ADDR_DATA_LO = 8'(ABO_IDX_DATA_LO * 4);
	localparam logic [7:0] ABO_ADDR_DATA_HI = 8'(ABO_IDX_DATA_HI * 4);
	localparam logic [7:0] ABO_ADDR_STATUS = 8'(ABO_IDX_STATUS * 4);
	localparam logic [7:0] ABO_ADDR_IRQ_STAT = 8'(ABO_IDX_IRQ_STAT * 4);
	localparam logic [7:0] ABO_ADDR_IRQ_MASK = 8'(ABO_IDX_IRQ_MASK * 4);

	// ****************************************************
	// reset values
	// ****************************************************
	localparam logic [7:0] ABO_TRIM_RST = 8'h00;
	localparam logic [7:0] ABO_SETUP_RST = 8'h00;
	localparam logic [ABO_NEV-1:0] ABO_MASK_RST = 3'h0;

	// ****************************************************
	// setup register fields
	// ****************************************************
	localparam int ABO_F_TYPE = 7;
	localparam int ABO_F_MODE_HI = 6;
	localparam int ABO_F_MODE_LO = 5;
	localparam int ABO_F_GATE = 4;
	localparam int ABO_F_TRIG_IN = 3;
	localparam int ABO_F_TRIG_OUT = 2;
	localparam int ABO_F_TRIG_TILT = 0;
	localparam logic [1:0] ABO_MODE_OFF = 2'h0;
	localparam logic [1:0] ABO_MODE_STREAM = 2'h1;
	localparam logic [1:0] ABO_MODE_STOP = 2'h2;
	localparam logic [1:0] ABO_MODE_TRIG = 2'h3;

	// ****************************************************
	// status and event bit positions
	// ****************************************************
	localparam int ABO_S_OVF = 6;
	localparam int ABO_S_TRIGGERED = 7;
	localparam int ABO_S_GATED = 8;
	localparam int ABO_EV_OVF = 0;
	localparam int ABO_EV_TRIG = 1;
	localparam int ABO_EV_DROP = 2;

endpackage

// ===== hw/abo_trim_add.sv
// one axis: raw sample plus doubled trim, clamped to 12-bit signed
// assumes raw and trim are two's complement
`timescale 1ns/1ps
`default_nettype none
module abo_trim_add (
	input wire logic signed [abo_pkg::ABO_SW-1:0] raw,
	input wire logic signed [abo_pkg::ABO_TW-1:0] trim,
	output logic signed [abo_pkg::ABO_SW-1:0] corrected
);
	import abo_pkg::*;

	localparam logic signed [ABO_SW+1:0] MAX_V = 14'sh07ff;
	localparam logic signed [ABO_SW+1:0] MIN_V = -14'sh0800;
	logic signed [ABO_SW+1:0] sum;

	// ****************************************************
	// scaled trim and clamp
	// ****************************************************
	// trim counts twice the output step
	assign sum = {{2{raw[ABO_SW-1]}}, raw}
		+ {{(ABO_SW+1-ABO_TW){trim[ABO_TW-1]}}, trim, 1'b0};

	always_comb begin
		if (sum > MAX_V) begin
			corrected = MAX_V[ABO_SW-1:0];
		end else if (sum < MIN_V) begin
			corrected = MIN_V[ABO_SW-1:0];
		end else begin
			corrected = sum[ABO_SW-1:0];
		end
	end
endmodule
`default_nettype wire

// ===== hw/abo_event_flag.sv
// one sticky event bit, cleared by software, set wins over clear
// assumes set and clear are one-cycle pulses on pclk
`timescale 1ns/1ps
`default_nettype none
module abo_event_flag (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic set,
	input wire logic clr,
	output logic flag
);
	// ****************************************************
	// sticky bit
	// ****************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag <= 1'b0;
		end else if (set) begin
			flag <= 1'b1;
		end else if (clr) begin
			flag <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ===== bench/abo_host.sv
// host model: apb master reaching the trim and buffer registers
// assumes the bench clock, a slave that ends each access with pready
`timescale 1ns/1ps
`default_nettype none
module abo_host (
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [abo_pkg::ABO_AW-1:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial begin
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = '0;
		pwdata = '0;
	end

	// one transfer; request held until the rising edge that samples pready high
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic err, output logic hung);
		int n;
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		hung = 1;
		for (n = 0; n < 50 && hung; n++) begin
			@(posedge pclk);
			if (pready === 1'b1) hung = 0;
		end
		r = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		pwdata <= ~d;
	endtask
endmodule
`default_nettype wire

// ===== bench/testbench.sv
// self-checking bench: queue model of trim and sample buffer
// assumes abo_pkg, abo_top and abo_host are compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import abo_pkg::*;
	logic pclk = 0, presetn = 0, psel, penable, pwrite, pready, pslverr, ov, ovf, irq;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r, tmp, seed = 32'he4e42324;
	logic sv = 0, act = 0, pin2 = 0, pmc = 0, fl = 0, ein = 0, eout = 0, etl = 0, e, h;
	logic [11:0] rx = 0, ry = 0, rz = 0, ox, oy, oz;
	logic [5:0] wm = 0, cnt;
	logic [35:0] q[$];
	logic [7:0] adr[4] = '{ABO_ADDR_TRIM_X, ABO_ADDR_TRIM_Y, ABO_ADDR_TRIM_Z, ABO_ADDR_SETUP};
	int trim[3] = '{0, 0, 0};
	int eb[3] = '{3, 2, 0};
	int md, typ, trig, post, bad_count = 0, tests_run = 0;

	always #12.5 pclk = ~pclk;

	abo_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	abo_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sample_valid(sv), .raw_x(rx), .raw_y(ry), .raw_z(rz),
		.sensor_active(act), .pin_two_function_select(pin2), .power_mode_change(pmc),
		.buffer_flush(fl), .change_inband_evt(ein), .change_outband_evt(eout),
		.tilt_change_evt(etl), .watermark_level(wm), .out_valid(ov), .out_x(ox), .out_y(oy),
		.out_z(oz), .buffer_overflow_flag(ovf), .buffer_count(cnt), .irq(irq));

	// ****************************************************
	// helpers
	// ****************************************************
	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [11:0] fix(input logic [11:0] raw, input int t);
		int v;
		v = int'(signed'(raw)) + 2 * t;
		if (v > 2047) v = 2047;
		if (v < -2048) v = -2048;
		return 12'(v);
	endfunction

	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		host.xfer(w, a, d, r, e, h);
		if (h) begin
			bad_count++;
			summarize();
		end
	endtask

	task automatic setup(input logic [7:0] v);
		acc(1, ABO_ADDR_SETUP, 32'h0);
		acc(1, ABO_ADDR_SETUP, {24'h0, v});
		q.delete();
		md = v[6:5];
		typ = v[7];
		trig = 0;
		post = 0;
	endtask

	task automatic pulse(input logic [4:0] v);
		@(posedge pclk);
		{pmc, fl, ein, eout, etl} <= v;
		@(posedge pclk);
		{pmc, fl, ein, eout, etl} <= 5'h0;
	endtask

	task automatic push(input logic [11:0] x, input logic [11:0] y, input logic [11:0] z);
		logic [35:0] s;
		s = {fix(z, trim[2]), fix(y, trim[1]), fix(x, trim[0])};
		@(posedge pclk);
		sv <= 1;
		rx <= x;
		ry <= y;
		rz <= z;
		@(posedge pclk);
		sv <= 0;
		@(negedge pclk);
		chk({ov, oz, oy, ox}, {1'b1, s}, "sample");
		if (md == 1) begin
			if (q.size() == 32) void'(q.pop_front());
			q.push_back(s);
		end else if (md == 2 && q.size() < 32) begin
			q.push_back(s);
		end else if (md == 3 && trig == 0) begin
			q.push_back(s);
			if (q.size() > wm) void'(q.pop_front());
		end else if (md == 3 && post < 32 - wm) begin
			q.push_back(s);
			post++;
		end
	endtask

	task automatic pr(input int n);
		repeat (n) begin
			tmp = rnd();
			push(tmp[11:0], tmp[23:12], tmp[31:20]);
		end
	endtask

	task automatic cnt_chk();
		repeat (3) @(negedge pclk);
		chk(cnt, 40'(q.size()), "count");
	endtask

	task automatic drain();
		logic [35:0] s;
		while (q.size() > 0) begin
			s = (typ == 1) ? q.pop_back() : q.pop_front();
			acc(0, ABO_ADDR_DATA_LO, 32'h0);
			chk({r[27:16], r[11:0]}, s[23:0], "read xy");
			acc(0, ABO_ADDR_DATA_HI, 32'h0);
			chk(r[11:0], s[35:24], "read z");
		end
	endtask

	// ****************************************************
	// main sequence
	// ****************************************************
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1;
		foreach (adr[i]) begin
			acc(0, adr[i], 32'h0);
			chk(r, 40'h0, "reset value");
		end
		acc(0, 8'h04, 32'h0);
		chk({e, r}, {1'b1, 32'h0}, "unmapped");
		$display("test reset done");
		tmp = rnd();
		trim = '{127, -128, int'(signed'(tmp[7:0]))};
		for (int i = 0; i < 3; i++) begin
			acc(1, adr[i], {24'h0, 8'(trim[i])});
			acc(0, adr[i], 32'h0);
			chk(r, {32'h0, 8'(trim[i])}, "trim");
		end
		setup(8'h00);
		push(12'h7ff, 12'h830, 12'h800);
		pr(4);
		cnt_chk();
		$display("test trim done");
		setup(8'h20);
		pr(35);
		cnt_chk();
		drain();
		$display("test stream done");
		setup(8'hc0);
		// lock test first: a rising active bit flushes the buffer
		for (int k = 0; k < 2; k++) begin
			act <= (k == 0);
			pin2 <= (k == 1);
			acc(1, ABO_ADDR_SETUP, 32'h20);
			acc(0, ABO_ADDR_SETUP, 32'h0);
			chk(r, 40'hc0, "locked setup");
		end
		act <= 0;
		pin2 <= 0;
		pr(34);
		cnt_chk();
		chk({ovf, irq}, 2'b10, "stop ovf");
		acc(0, ABO_ADDR_IRQ_STAT, 32'h0);
		chk(r[0], 1'b1, "irq status");
		acc(1, ABO_ADDR_IRQ_MASK, 32'h1);
		repeat (2) @(negedge pclk);
		chk(irq, 1'b1, "irq raised");
		acc(1, ABO_ADDR_IRQ_STAT, 32'h1);
		repeat (2) @(negedge pclk);
		chk(irq, 1'b0, "irq cleared");
		drain();
		pr(34);
		chk(ovf, 1'b1, "refill ovf");
		setup(8'h20);
		cnt_chk();
		chk(ovf, 1'b0, "disable clears ovf");
		$display("test stop done");
		wm <= 6'h4;
		for (int s = 0; s < 3; s++) begin
			setup(8'h60 | 8'(1 << eb[s]));
			pr(10);
			cnt_chk();
			pulse(5'(4 >> ((s + 1) % 3)));
			pr(2);
			cnt_chk();
			pulse(5'(4 >> s));
			trig = 1;
			pr(40);
			cnt_chk();
			chk(ovf, 1'b1, "trigger ovf");
			drain();
			repeat (3) @(negedge pclk);
			chk(ovf, 1'b0, "readout clears ovf");
			trig = 0;
			post = 0;
			pr(6);
			cnt_chk();
		end
		$display("test trigger done");
		setup(8'h20);
		pr(3);
		pulse(5'h10);
		q.delete();
		cnt_chk();
		setup(8'h30);
		pr(3);
		pulse(5'h10);
		cnt_chk();
		pulse(5'h08);
		q.delete();
		cnt_chk();
		$display("test power change done");
		summarize();
	end

	initial begin
		repeat (100000) @(posedge pclk);
		bad_count++;
		summarize();
	end
endmodule
`default_nettype wire
